// file: core/cic_controller.sv
// Purpose: Interrupt controller for a small embedded CPU core
// Assumes: CPU reports instruction ends and long-call timing itself
// Notes:   All register contents arrive as plain ports, no bus
// Notes on behaviour
// - Taken source jumps to fixed address, 0x03 upward by eight, extended from 0x43.
// - Handler runs to its return unless a higher level request preempts it.
// - Same-level ties go to the lowest natural priority number, 1 to 11.
// - Each source has high or low level; level beats natural order.
// - Only a strictly higher level preempts; high handlers are never interrupted.
// - The current instruction always finishes before any service starts.
// - After a return or enable/priority write, one more instruction runs first.
// - Global enable bit 7 low masks every source.
// - With global enable set, each source follows its own enable bit.
// - Extended flags at bits 7..4, wake flag bit 3, enables bits 4..0.
// - External pins are sampled once per instruction cycle, at phase four.
// - Both pins are active low with a level or edge select each.
// - Level mode sets on a low sample; edge mode on high then low.
// - Timers and serial port request by their own flag bits.
// - Fastest response: one cycle to detect, four for the long call.
// - Worst response thirteen cycles, 52 clocks, return then multiply or divide.
// - Writing 0x2 or 0x3 to clock and power control starts shutdown.
// - Power-down ends only on a pin, wake timer, or watchdog reset.
// - Wake holds response for recovery; shutdown also takes slow cycles.
// - After a return, at least one program instruction runs before re-entry.
// - Extended flags set on a rising source edge and stay until cleared.
// - Software setting an extended flag raises it like hardware does.
`timescale 1ns/1ps
`default_nettype none
module cic_controller (
  input  wire logic       CLK,                     // CPU clock, 10 MHz
  input  wire logic       RESET_N,                 // Async reset, active low
  input  wire logic       EXT_IRQ0_N,              // External pin 0, active low
  input  wire logic       EXT_IRQ1_N,              // External pin 1, active low
  input  wire logic       EXT0_TRIGGER_SELECT,     // 1 = edge mode for pin 0
  input  wire logic       EXT1_TRIGGER_SELECT,     // 1 = edge mode for pin 1
  input  wire logic [7:0] BASIC_IRQ_ENABLE_REG,    // Bit 7 global, 5..0 sources
  input  wire logic [5:0] BASIC_IRQ_PRIORITY_REG,  // 1 = high level
  input  wire logic [4:0] EXT_SOURCE_ENABLES,      // Extended and wake enables
  input  wire logic [4:0] EXT_SOURCE_PRIORITIES,   // Extended and wake levels
  input  wire logic       TIMER0_FLAG,             // Timer 0 overflow flag
  input  wire logic       TIMER1_FLAG,             // Timer 1 overflow flag
  input  wire logic       SERIAL_FLAG,             // Serial transmit or receive flag
  input  wire logic       TIMER2_FLAG,             // Timer 2 flag
  input  wire logic       ADC_DONE_IRQ,            // ADC end of conversion
  input  wire logic       SPI_DONE_IRQ,            // Internal SPI byte done
  input  wire logic       RADIO_DATA_READY_1,      // Radio data ready 1
  input  wire logic       RADIO_DATA_READY_2,      // Radio data ready 2
  input  wire logic       WAKE_TIMER_EVENT,        // Wake timer expiry
  input  wire logic [4:0] FLAG_SET,                // Software set: adc,spi,r1,r2,wake
  input  wire logic [4:0] FLAG_CLR,                // Software clear, same order
  input  wire logic [1:0] EXT_PIN_FLAG_CLR,        // Software clear of pin flags
  input  wire logic       INSTR_END,               // Instruction finishes this cycle
  input  wire logic       INSTR_IS_RETURN,         // Finishing one is a handler return
  input  wire logic       INSTR_WROTE_IRQ_REGS,    // Finishing one wrote enable/priority
  input  wire logic       CLOCK_POWER_WR,          // Write strobe to clock_power_ctrl
  input  wire logic [7:0] CLOCK_POWER_DATA,        // Value written
  input  wire logic       SLOW_OSCILLATOR,         // Slow oscillator clock, async
  output logic            IRQ_TAKE,                // Pulse: start long call
  output logic [7:0]      IRQ_VECTOR,              // Handler address, held
  output logic [3:0]      EXT_SOURCE_FLAGS,        // Flags adc,spi,r1,r2 (bits 7..4)
  output logic            WAKE_TIMER_FLAG,         // Wake flag (bit 3)
  output logic            EXT0_PENDING_FLAG,       // Pin 0 pending
  output logic            EXT1_PENDING_FLAG,       // Pin 1 pending
  output logic            IN_SERVICE_HIGH,         // High level handler active
  output logic            IN_SERVICE_LOW,          // Low level handler active
  output logic            CPU_HOLD                 // Core held for power sequencing
);
  typedef enum logic [1:0] {PW_RUN, PW_SHUT, PW_DOWN, PW_WAKE} cic_pw_t;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Lowest set index of a request vector, natural order
  function automatic logic [3:0] cic_pick(input logic [10:0] req);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = cic_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // Handler address of a source index
  function automatic logic [7:0] cic_vector(input logic [3:0] idx);
    logic [7:0] v;
    if (idx == cic_pkg::SRC_WAKE) begin
      v = cic_pkg::VEC_WAKE;
    end else if (idx >= cic_pkg::SRC_ADC) begin
      v = cic_pkg::VEC_EXT_BASE + 8'((idx - cic_pkg::SRC_ADC) * cic_pkg::VEC_STEP);
    end else begin
      v = cic_pkg::VEC_BASE + 8'(idx * cic_pkg::VEC_STEP);
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin samplers

  logic fourth_phase;
  logic pin0_low, pin1_low;
  logic take_next;
  logic [3:0] sel;
  logic clr_pin0, clr_pin1;

  cic_phase_div u_phase (
    .clk          (CLK),
    .reset_n      (RESET_N),
    .fourth_phase (fourth_phase)
  );

  // Edge flags clear when the core vectors to their handler
  assign clr_pin0 = (take_next && sel == cic_pkg::SRC_EXT0) || EXT_PIN_FLAG_CLR[0];
  assign clr_pin1 = (take_next && sel == cic_pkg::SRC_EXT1) || EXT_PIN_FLAG_CLR[1];

  cic_pin_sampler u_pin0 (
    .clk       (CLK),
    .reset_n   (RESET_N),
    .pin_n     (EXT_IRQ0_N),
    .phase     (fourth_phase),
    .trig_edge (EXT0_TRIGGER_SELECT),
    .clr       (clr_pin0),
    .pending   (EXT0_PENDING_FLAG),
    .pin_low   (pin0_low)
  );

  cic_pin_sampler u_pin1 (
    .clk       (CLK),
    .reset_n   (RESET_N),
    .pin_n     (EXT_IRQ1_N),
    .phase     (fourth_phase),
    .trig_edge (EXT1_TRIGGER_SELECT),
    .clr       (clr_pin1),
    .pending   (EXT1_PENDING_FLAG),
    .pin_low   (pin1_low)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Extended source flags

  logic [4:0] src_now, src_prev_reg, xflag_next;
  assign src_now = {WAKE_TIMER_EVENT, RADIO_DATA_READY_2, RADIO_DATA_READY_1,
                    SPI_DONE_IRQ, ADC_DONE_IRQ};

  // Rising edge or software set; set wins over a same-cycle clear
  always_comb begin
    xflag_next = ((src_now & ~src_prev_reg) | FLAG_SET)
               | ({WAKE_TIMER_FLAG, EXT_SOURCE_FLAGS} & ~FLAG_CLR);
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      src_prev_reg     <= 5'h00;
      EXT_SOURCE_FLAGS <= 4'h0;
      WAKE_TIMER_FLAG  <= 1'b0;
    end else begin
      src_prev_reg     <= src_now;
      EXT_SOURCE_FLAGS <= xflag_next[3:0];
      WAKE_TIMER_FLAG  <= xflag_next[4];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration and vectoring

  logic [10:0] pend, en, lvl, req, hi_req, lo_req;
  logic        hi_sel, may_take;
  logic        ins_hi_next, ins_lo_next;
  logic [7:0]  vec_next;
  logic        ret_end;

  assign pend = {WAKE_TIMER_FLAG, EXT_SOURCE_FLAGS, TIMER2_FLAG, SERIAL_FLAG,
                 TIMER1_FLAG, EXT1_PENDING_FLAG, TIMER0_FLAG, EXT0_PENDING_FLAG};
  assign en   = {EXT_SOURCE_ENABLES, BASIC_IRQ_ENABLE_REG[cic_pkg::NUM_BASIC-1:0]};
  assign lvl  = {EXT_SOURCE_PRIORITIES, BASIC_IRQ_PRIORITY_REG};
  assign ret_end = INSTR_END && INSTR_IS_RETURN;

  // Masking, level split and selection are one combinational step
  always_comb begin
    req     = BASIC_IRQ_ENABLE_REG[cic_pkg::GLOBAL_EN_BIT] ? (pend & en) : 11'h000;
    hi_req  = req & lvl;
    lo_req  = req & ~lvl;
    // A high handler blocks all; a low handler blocks low requests
    hi_sel  = (hi_req != 11'h000) && !IN_SERVICE_HIGH;
    sel     = hi_sel ? cic_pick(hi_req) : cic_pick(lo_req);
    // Only at an instruction end, and not after a return or a mask write,
    // so one more instruction of the interrupted code always runs
    may_take = INSTR_END && !INSTR_IS_RETURN && !INSTR_WROTE_IRQ_REGS
             && !CPU_HOLD;
    take_next = may_take && (hi_sel ||
                ((lo_req != 11'h000) && !IN_SERVICE_HIGH && !IN_SERVICE_LOW));
    vec_next = take_next ? cic_vector(sel) : IRQ_VECTOR;
    // Handler levels; a return ends the innermost (highest) one
    ins_hi_next = IN_SERVICE_HIGH;
    ins_lo_next = IN_SERVICE_LOW;
    if (ret_end) begin
      if (IN_SERVICE_HIGH) begin
        ins_hi_next = 1'b0;
      end else begin
        ins_lo_next = 1'b0;
      end
    end
    if (take_next) begin
      if (hi_sel) begin
        ins_hi_next = 1'b1;
      end else begin
        ins_lo_next = 1'b1;
      end
    end
  end

  // The take pulse leaves one cycle after the detect point; the core then
  // spends four instruction cycles on the long call, so total latency lies
  // between five and thirteen instruction cycles depending on the core
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      IRQ_TAKE        <= 1'b0;
      IRQ_VECTOR      <= 8'h00;
      IN_SERVICE_HIGH <= 1'b0;
      IN_SERVICE_LOW  <= 1'b0;
    end else begin
      IRQ_TAKE        <= take_next;
      IRQ_VECTOR      <= vec_next;
      IN_SERVICE_HIGH <= ins_hi_next;
      IN_SERVICE_LOW  <= ins_lo_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-down sequencing

  logic    so1_reg, so2_reg, so3_reg, so_filt_reg, so_filt_next, slow_tick;
  cic_pw_t pw_reg, pw_next;
  logic [2:0] slow_cnt_reg, slow_cnt_next;
  logic    wake_evt, down_wr;

  // Slow clock is foreign: three flops, edge counted once stages agree
  always_comb begin
    so_filt_next = (so2_reg == so3_reg) ? so3_reg : so_filt_reg;
    slow_tick    = so_filt_next && !so_filt_reg;
  end

  assign down_wr  = CLOCK_POWER_WR && (CLOCK_POWER_DATA == cic_pkg::CP_DOWN_A ||
                                       CLOCK_POWER_DATA == cic_pkg::CP_DOWN_B);
  // Watchdog reset arrives through RESET_N; enables play no part here
  assign wake_evt = pin0_low || pin1_low || WAKE_TIMER_EVENT;

  always_comb begin
    pw_next       = pw_reg;
    slow_cnt_next = slow_cnt_reg;
    unique case (pw_reg)
      PW_RUN: begin
        if (down_wr) begin
          pw_next       = PW_SHUT;
          slow_cnt_next = 3'h0;
        end
      end
      PW_SHUT: begin
        if (slow_tick) begin
          slow_cnt_next = slow_cnt_reg + 3'h1;
        end
        if (slow_tick && slow_cnt_reg == cic_pkg::SHUT_SLOW_CYC - 3'h1) begin
          pw_next = PW_DOWN;
        end
      end
      PW_DOWN: begin
        if (wake_evt) begin
          pw_next       = PW_WAKE;
          slow_cnt_next = 3'h0;
        end
      end
      PW_WAKE: begin
        if (slow_tick) begin
          slow_cnt_next = slow_cnt_reg + 3'h1;
        end
        if (slow_tick && slow_cnt_reg == cic_pkg::WAKE_SLOW_CYC - 3'h1) begin
          pw_next = PW_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      so1_reg      <= 1'b0;
      so2_reg      <= 1'b0;
      so3_reg      <= 1'b0;
      so_filt_reg  <= 1'b0;
      pw_reg       <= PW_RUN;
      slow_cnt_reg <= 3'h0;
      CPU_HOLD     <= 1'b0;
    end else begin
      so1_reg      <= SLOW_OSCILLATOR;
      so2_reg      <= so1_reg;
      so3_reg      <= so2_reg;
      so_filt_reg  <= so_filt_next;
      pw_reg       <= pw_next;
      slow_cnt_reg <= slow_cnt_next;
      CPU_HOLD     <= (pw_next != PW_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  a_global_mask_off: assert property (
    !BASIC_IRQ_ENABLE_REG[cic_pkg::GLOBAL_EN_BIT] |=> !IRQ_TAKE)
    else $error("Interrupt taken with global enable low");
  a_take_at_boundary: assert property (
    IRQ_TAKE |-> $past(INSTR_END))
    else $error("Interrupt taken mid instruction");
  a_one_more_instr: assert property (
    (INSTR_END && (INSTR_IS_RETURN || INSTR_WROTE_IRQ_REGS)) |=> !IRQ_TAKE)
    else $error("Interrupt taken right after return or mask write");
  a_high_not_preempt: assert property (
    IN_SERVICE_HIGH && !ret_end |=> !IRQ_TAKE)
    else $error("High level handler preempted");
  a_level_wins: assert property (
    (may_take && hi_req != 11'h000 && !IN_SERVICE_HIGH)
      |=> IRQ_TAKE && IN_SERVICE_HIGH)
    else $error("High level request not chosen first");
  a_ext0_vector: assert property (
    (take_next && sel == cic_pkg::SRC_EXT0) |=> IRQ_VECTOR == cic_pkg::VEC_BASE)
    else $error("Wrong handler address for pin 0");
  a_edge_auto_clear: assert property (
    (take_next && sel == cic_pkg::SRC_EXT0 && EXT0_TRIGGER_SELECT && !fourth_phase)
      |=> !EXT0_PENDING_FLAG)
    else $error("Edge flag not cleared on vectoring");
  a_adc_rise_sticky: assert property (
    $rose(ADC_DONE_IRQ) |=> EXT_SOURCE_FLAGS[0])
    else $error("ADC edge did not set its flag");
  a_soft_set_flag: assert property (
    FLAG_SET[1] |=> EXT_SOURCE_FLAGS[1])
    else $error("Software set of SPI flag lost");
  a_shutdown_holds: assert property (
    (pw_reg == PW_RUN && down_wr) |=> CPU_HOLD [*2])
    else $error("Shutdown write did not hold the core");
  a_no_take_in_hold: assert property (
    CPU_HOLD |=> !IRQ_TAKE)
    else $error("Interrupt taken during power sequencing");

  c_take_low:   cover property (IRQ_TAKE && IN_SERVICE_LOW && !IN_SERVICE_HIGH);
  c_preempt:    cover property (IN_SERVICE_LOW && IRQ_TAKE && IN_SERVICE_HIGH);
  c_wake_back:  cover property (pw_reg == PW_WAKE ##1 pw_reg == PW_RUN);
  c_wake_timer: cover property (IRQ_TAKE && IRQ_VECTOR == cic_pkg::VEC_WAKE);
endmodule
`default_nettype wire

// file: core/cic_phase_div.sv
// Purpose: Instruction cycle phase divider
// Assumes: Four CPU clocks per instruction cycle
// Notes:   Output pulse marks the clock edge that ends the fourth phase
`timescale 1ns/1ps
`default_nettype none
module cic_phase_div (
  input  wire logic clk,          // CPU clock
  input  wire logic reset_n,      // Async reset, active low
  output logic      fourth_phase  // One-cycle pulse per instruction cycle
);
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic       ph_next;

  // Free running phase count
  always_comb begin
    cnt_next = cnt_reg + 2'h1;
    ph_next  = (cnt_reg == cic_pkg::PHASE_LAST);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg      <= 2'h0;
      fourth_phase <= 1'b0;
    end else begin
      cnt_reg      <= cnt_next;
      fourth_phase <= ph_next;
    end
  end
endmodule
`default_nettype wire

// file: core/cic_pin_sampler.sv
// Purpose: Active-low external interrupt pin sampler and pending flag
// Assumes: Pin is asynchronous; phase pulse comes from the divider
// Notes:   Level mode flag follows the sample and is never latched
`timescale 1ns/1ps
`default_nettype none
module cic_pin_sampler (
  input  wire logic clk,        // CPU clock
  input  wire logic reset_n,    // Async reset, active low
  input  wire logic pin_n,      // External request pin, active low
  input  wire logic phase,      // Fourth phase pulse
  input  wire logic trig_edge,  // 1 selects falling edge detection
  input  wire logic clr,        // Clears a latched edge request
  output logic      pending,    // Pending flag
  output logic      pin_low     // Filtered pin level, used for wakeup
);
  logic s1_reg, s2_reg, s3_reg;
  logic filt_reg, filt_next;
  logic samp_reg, samp_next;
  logic pend_next;
  logic edge_set;

  // Three stage synchroniser; a change counts once stages two and three agree
  always_comb begin
    filt_next = (s2_reg == s3_reg) ? s3_reg : filt_reg;
    samp_next = phase ? filt_reg : samp_reg;
    edge_set  = phase && samp_reg && !filt_reg;
    if (trig_edge) begin
      pend_next = edge_set || (pending && !clr);
    end else begin
      pend_next = phase ? !filt_reg : pending;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg   <= 1'b1;
      s2_reg   <= 1'b1;
      s3_reg   <= 1'b1;
      filt_reg <= 1'b1;
      samp_reg <= 1'b1;
      pending  <= 1'b0;
      pin_low  <= 1'b0;
    end else begin
      s1_reg   <= pin_n;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= filt_next;
      samp_reg <= samp_next;
      pending  <= pend_next;
      pin_low  <= !filt_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_flag_only_on_phase: assert property (
    (!trig_edge && $changed(pending) && $past(!trig_edge)) |-> $past(phase))
    else $error("Level flag moved outside the fourth phase");
  a_edge_needs_high_low: assert property (
    (trig_edge && $rose(pending)) |-> $past(samp_reg && !filt_reg))
    else $error("Edge flag set without high then low samples");
endmodule
`default_nettype wire

// file: core/cic_pkg.sv
// Purpose: Shared constants for the CPU interrupt controller
// Assumes: Four CPU clocks per instruction cycle
// Notes:   Source index order is the natural priority order
package cic_pkg;
  localparam int unsigned NUM_SRC        = 11;
  localparam int unsigned PHASE_W        = 2;
  localparam logic [1:0]  PHASE_LAST     = 2'h3;   // Fourth phase of the cycle
  // Source indices, lowest index wins a tie
  localparam logic [3:0]  SRC_EXT0       = 4'h0;
  localparam logic [3:0]  SRC_TMR0       = 4'h1;
  localparam logic [3:0]  SRC_EXT1       = 4'h2;
  localparam logic [3:0]  SRC_TMR1       = 4'h3;
  localparam logic [3:0]  SRC_SERIAL     = 4'h4;
  localparam logic [3:0]  SRC_TMR2       = 4'h5;
  localparam logic [3:0]  SRC_ADC        = 4'h6;
  localparam logic [3:0]  SRC_WAKE       = 4'ha;
  localparam int unsigned NUM_BASIC      = 6;
  localparam int unsigned NUM_EXT        = 5;
  // Handler addresses
  localparam logic [7:0]  VEC_BASE       = 8'h03;
  localparam logic [7:0]  VEC_EXT_BASE   = 8'h43;
  localparam logic [7:0]  VEC_STEP       = 8'h08;
  localparam logic [7:0]  VEC_WAKE       = 8'h63;
  // Bit positions
  localparam int unsigned GLOBAL_EN_BIT  = 7;
  localparam int unsigned EXT_FLAG_LSB   = 4;      // Extended flags sit at bits 7..4
  localparam int unsigned WAKE_FLAG_BIT  = 3;
  // Clock and power control values that start a shutdown
  localparam logic [7:0]  CP_DOWN_A      = 8'h02;
  localparam logic [7:0]  CP_DOWN_B      = 8'h03;
  // Slow oscillator periods, worst case of each documented range
  localparam logic [2:0]  SHUT_SLOW_CYC  = 3'h3;
  localparam logic [2:0]  WAKE_SLOW_CYC  = 3'h4;
endpackage

// file: verif/cic_core_model.sv
// Purpose: Behavioural CPU core that ends instructions and runs long calls
// Assumes: Four clocks per instruction, long call busy for four instructions
// Notes:   The bench asks for a handler return through ret_req
`timescale 1ns/1ps
`default_nettype none
module cic_core_model (
  input  wire logic clk,       // CPU clock
  input  wire logic reset_n,   // Async reset, active low
  input  wire logic irq_take,  // Long call request
  input  wire logic ret_req,   // Next boundary is a return
  output logic      instr_end, // Last cycle of an instruction
  output logic      instr_ret  // That instruction is a return
);
  logic [1:0] ph_reg, ph_next;
  logic [4:0] call_reg, call_next;
  // Next phase and long call holdoff, sixteen clocks
  always_comb begin
    ph_next = ph_reg + 2'h1;
    call_next = irq_take ? 5'h10 : (call_reg != 5'h00 ? call_reg - 5'h01 : 5'h00);
  end
  // State registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ph_reg <= 2'h0;
      call_reg <= 5'h00;
    end else begin
      ph_reg <= ph_next;
      call_reg <= call_next;
    end
  end
  // No boundary while the call fetches the handler, so nothing is taken twice
  assign instr_end = ph_reg == 2'h3 && call_reg == 5'h00 && !irq_take;
  assign instr_ret = instr_end && ret_req;
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Purpose: Self-checking bench for the interrupt controller
// Assumes: Core model paces instruction boundaries
// Notes:   Table rows first, then pin, nesting and power cases
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; $display("wrong value %0t: %h vs %h", $time, a, b); end end
module tb_top;
  typedef struct {logic [7:0] be; logic [3:0] t; logic [4:0] e, s; logic [5:0] bp;
                  logic [4:0] xp; logic tk; logic [7:0] v; logic hi;} cic_row_t;
  logic CLK = 0, RESET_N = 0, EXT_IRQ0_N = 1, EXT_IRQ1_N = 1, ret = 0, f;
  logic EXT0_TRIGGER_SELECT = 0, EXT1_TRIGGER_SELECT = 0, INSTR_WROTE_IRQ_REGS = 0;
  logic TIMER0_FLAG = 0, TIMER1_FLAG = 0, SERIAL_FLAG = 0, TIMER2_FLAG = 0, ADC_DONE_IRQ = 0;
  logic SPI_DONE_IRQ = 0, RADIO_DATA_READY_1 = 0, RADIO_DATA_READY_2 = 0, WAKE_TIMER_EVENT = 0;
  logic CLOCK_POWER_WR = 0, SLOW_OSCILLATOR = 0, IRQ_TAKE, WAKE_TIMER_FLAG, CPU_HOLD;
  logic EXT0_PENDING_FLAG, EXT1_PENDING_FLAG, IN_SERVICE_HIGH, IN_SERVICE_LOW;
  logic [7:0] BASIC_IRQ_ENABLE_REG = 0, CLOCK_POWER_DATA = 0, IRQ_VECTOR;
  logic [5:0] BASIC_IRQ_PRIORITY_REG = 0;
  logic [4:0] EXT_SOURCE_ENABLES = 5'h1F, EXT_SOURCE_PRIORITIES = 0, FLAG_SET = 0, FLAG_CLR = 0;
  logic [3:0] EXT_SOURCE_FLAGS;
  logic [1:0] EXT_PIN_FLAG_CLR = 0;
  wire        INSTR_END, INSTR_IS_RETURN;
  int         err_total = 0, checks = 0;
  // Enables, timer flags, edges, soft sets, priorities, take, vector, high level
  cic_row_t rows[14] = '{
    '{8'hBF, 4'h1, 5'h00, 5'h00, 6'h00, 5'h00, 1'b1, 8'h0B, 1'b0},
    '{8'hBF, 4'h2, 5'h00, 5'h00, 6'h00, 5'h00, 1'b1, 8'h1B, 1'b0},
    '{8'hBF, 4'h4, 5'h00, 5'h00, 6'h00, 5'h00, 1'b1, 8'h23, 1'b0},
    '{8'hBF, 4'h8, 5'h00, 5'h00, 6'h00, 5'h00, 1'b1, 8'h2B, 1'b0},
    '{8'hBF, 4'h0, 5'h01, 5'h00, 6'h00, 5'h00, 1'b1, 8'h43, 1'b0},
    '{8'hBF, 4'h0, 5'h00, 5'h02, 6'h00, 5'h00, 1'b1, 8'h4B, 1'b0},
    '{8'hBF, 4'h0, 5'h04, 5'h00, 6'h00, 5'h00, 1'b1, 8'h53, 1'b0},
    '{8'hBF, 4'h0, 5'h00, 5'h08, 6'h00, 5'h00, 1'b1, 8'h5B, 1'b0},
    '{8'hBF, 4'h0, 5'h10, 5'h00, 6'h00, 5'h00, 1'b1, 8'h63, 1'b0},
    '{8'hBF, 4'h1, 5'h00, 5'h01, 6'h00, 5'h00, 1'b1, 8'h0B, 1'b0},
    '{8'hBF, 4'h1, 5'h00, 5'h01, 6'h00, 5'h01, 1'b1, 8'h43, 1'b1},
    '{8'hBF, 4'h3, 5'h00, 5'h00, 6'h08, 5'h00, 1'b1, 8'h1B, 1'b1},
    '{8'h3F, 4'h1, 5'h00, 5'h00, 6'h00, 5'h00, 1'b0, 8'h00, 1'b0},
    '{8'hBD, 4'h1, 5'h00, 5'h00, 6'h00, 5'h00, 1'b0, 8'h00, 1'b0}};

  cic_controller dut_u (.*);
  cic_core_model core_u (.clk(CLK), .reset_n(RESET_N), .irq_take(IRQ_TAKE), .ret_req(ret),
                         .instr_end(INSTR_END), .instr_ret(INSTR_IS_RETURN));

  always #50 CLK = ~CLK;
  // Slow oscillator runs free at twenty CPU clocks a period
  always #1000 SLOW_OSCILLATOR = ~SLOW_OSCILLATOR;

  task automatic give_verdict;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Bounded wait for the take pulse, sampled after the edge settles
  task automatic wait_take(output logic got);
    got = 1'b0;
    repeat (40) begin
      @(posedge CLK);
      #1;
      if (IRQ_TAKE === 1'b1) begin
        got = 1'b1;
        break;
      end
    end
  endtask
  // Hold the return request until a boundary takes it
  task automatic do_ret;
    @(posedge CLK);
    ret <= 1'b1;
    repeat (24) begin
      @(posedge CLK);
      if (INSTR_END && INSTR_IS_RETURN) break;
    end
    ret <= 1'b0;
    @(posedge CLK);
  endtask

  initial begin
    #2_000_000;
    err_total++;
    give_verdict;
  end

  initial begin
    repeat (12) @(posedge CLK);
    RESET_N <= 1'b1;
    #1 `CHK({IRQ_TAKE, CPU_HOLD, IN_SERVICE_LOW}, 3'h0)
    foreach (rows[i]) begin
      @(posedge CLK);
      BASIC_IRQ_ENABLE_REG <= rows[i].be;
      BASIC_IRQ_PRIORITY_REG <= rows[i].bp;
      EXT_SOURCE_PRIORITIES <= rows[i].xp;
      {TIMER2_FLAG, SERIAL_FLAG, TIMER1_FLAG, TIMER0_FLAG} <= rows[i].t;
      {WAKE_TIMER_EVENT, RADIO_DATA_READY_2, RADIO_DATA_READY_1, SPI_DONE_IRQ, ADC_DONE_IRQ} <= rows[i].e;
      FLAG_SET <= rows[i].s;
      @(posedge CLK);
      FLAG_SET <= 5'h00;
      wait_take(f);
      `CHK(f, rows[i].tk)
      `CHK({WAKE_TIMER_FLAG, EXT_SOURCE_FLAGS}, rows[i].e | rows[i].s)
      if (f) `CHK({IRQ_VECTOR, IN_SERVICE_HIGH}, {rows[i].v, rows[i].hi})
      @(posedge CLK);
      {TIMER2_FLAG, SERIAL_FLAG, TIMER1_FLAG, TIMER0_FLAG} <= 4'h0;
      {WAKE_TIMER_EVENT, RADIO_DATA_READY_2, RADIO_DATA_READY_1, SPI_DONE_IRQ, ADC_DONE_IRQ} <= 5'h00;
      FLAG_CLR <= 5'h1F;
      @(posedge CLK);
      FLAG_CLR <= 5'h00;
      if (f) do_ret;
    end
    // Level pin enters low, then a high extended source nests on top
    @(posedge CLK);
    BASIC_IRQ_ENABLE_REG <= 8'h84;
    EXT_SOURCE_ENABLES <= 5'h01;
    EXT_SOURCE_PRIORITIES <= 5'h01;
    EXT_IRQ1_N <= 1'b0;
    wait_take(f);
    `CHK({f, IRQ_VECTOR, IN_SERVICE_LOW, EXT1_PENDING_FLAG}, {1'b1, 8'h13, 2'b11})
    @(posedge CLK);
    EXT_IRQ1_N <= 1'b1;
    FLAG_SET <= 5'h01;
    @(posedge CLK);
    FLAG_SET <= 5'h00;
    wait_take(f);
    `CHK({f, IRQ_VECTOR, IN_SERVICE_HIGH, IN_SERVICE_LOW}, {1'b1, 8'h43, 2'b11})
    @(posedge CLK);
    FLAG_CLR <= 5'h01;
    do_ret;
    FLAG_CLR <= 5'h00;
    do_ret;
    `CHK({IN_SERVICE_HIGH, IN_SERVICE_LOW}, 2'b00)
    // Boundaries that write the mask registers refuse the take; a later one serves it
    INSTR_WROTE_IRQ_REGS <= 1'b1;
    FLAG_SET <= 5'h01;
    repeat (9) begin
      @(posedge CLK);
      FLAG_SET <= 5'h00;
      `CHK(IRQ_TAKE, 1'b0)
    end
    INSTR_WROTE_IRQ_REGS <= 1'b0;
    wait_take(f);
    `CHK({f, IRQ_VECTOR, IN_SERVICE_HIGH}, {1'b1, 8'h43, 1'b1})
    @(posedge CLK);
    FLAG_CLR <= 5'h01;
    do_ret;
    FLAG_CLR <= 5'h00;
    // Edge mode on pin 0: flag clears on vectoring, and by software
    EXT0_TRIGGER_SELECT <= 1'b1;
    BASIC_IRQ_ENABLE_REG <= 8'h81;
    EXT_IRQ0_N <= 1'b0;
    wait_take(f);
    `CHK({f, IRQ_VECTOR, EXT0_PENDING_FLAG}, {1'b1, 8'h03, 1'b0})
    do_ret;
    BASIC_IRQ_ENABLE_REG <= 8'h00;
    EXT_IRQ0_N <= 1'b1;
    repeat (8) @(posedge CLK);
    EXT_IRQ0_N <= 1'b0;
    repeat (12) @(posedge CLK);
    `CHK(EXT0_PENDING_FLAG, 1'b1)
    EXT_PIN_FLAG_CLR <= 2'b01;
    @(posedge CLK);
    EXT_PIN_FLAG_CLR <= 2'b00;
    EXT_IRQ0_N <= 1'b1;
    @(posedge CLK);
    `CHK(EXT0_PENDING_FLAG, 1'b0)
    // Power-down holds the core until a wake event and recovery
    BASIC_IRQ_ENABLE_REG <= 8'h00;
    CLOCK_POWER_WR <= 1'b1;
    CLOCK_POWER_DATA <= 8'h02;
    @(posedge CLK);
    CLOCK_POWER_WR <= 1'b0;
    #1 `CHK(CPU_HOLD, 1'b1)
    repeat (300) @(posedge CLK);
    `CHK(CPU_HOLD, 1'b1)
    WAKE_TIMER_EVENT <= 1'b1;
    repeat (140) @(posedge CLK);
    #1 `CHK(CPU_HOLD, 1'b0)
    give_verdict;
  end
endmodule
`default_nettype wire
